// ---- prr_defines.svh ----
// register offsets, field positions and reset values for the page relocation
// unit; assumes a 32-bit register port addressed in bytes
`ifndef PRR_DEFINES_SVH
`define PRR_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PRR_OFF_CTRL 8'h00
`define PRR_OFF_STATUS 8'h04
`define PRR_OFF_MASK 8'h08
`define PRR_OFF_MODE 8'h0c
`define PRR_OFF_MAP_PTR 8'h10
`define PRR_OFF_MAP_DATA 8'h14
`define PRR_OFF_FAULT_ADDR 8'h18

// ****************************************************************
// page map entry fields
// ****************************************************************
`define PRR_EXCL_BIT 11
`define PRR_QLEN_MSB 10
`define PRR_QLEN_LSB 9
`define PRR_PAGE_MSB 8
`define PRR_PAGE_LSB 2
`define PRR_SQ_MSB 1
`define PRR_SQ_LSB 0

// ****************************************************************
// program address fields
// ****************************************************************
`define PRR_PA_LOC_MSB 14
`define PRR_PA_LOC_LSB 12
`define PRR_PA_HALF_BIT 11
`define PRR_PA_QTR_MSB 10
`define PRR_PA_QTR_LSB 9
`define PRR_PA_WORD_MSB 8

// ****************************************************************
// control and status fields, reset values
// ****************************************************************
`define PRR_CTRL_IGRP_LSB 0
`define PRR_CTRL_OGRP_LSB 4
`define PRR_ST_EXCL 0
`define PRR_ST_UNADDR 1
`define PRR_ST_QLEN 2
`define PRR_STATUS_RST 3'h0
`define PRR_MASK_RST 3'h0
`define PRR_GROUP_RST 3'h0

`endif

// ---- prr_pkg.sv ----
// types shared by the page relocation unit modules
// assumes prr_defines.svh sits beside it
package prr_pkg;

    // addressing mode; gray order along enter-program and operand relocation
    typedef enum logic [1:0] {
        PRR_MON_INIT = 2'h0,
        PRR_MON_OPER = 2'h1,
        PRR_PROG_OPER = 2'h3,
        PRR_PROG_INSTR = 2'h2
    } prr_mode_t;

    // whole state of the top module
    typedef struct packed {
        prr_mode_t mode;
        logic [2:0] instrGroup;
        logic [2:0] operGroup;
        logic [6:0] mapPtr;
        logic [2:0] status;
        logic [2:0] mask;
        logic [2:0] lastGroup;
        logic [17:0] faultAddr;
        logic [17:0] coreAddr;
        logic coreLeft;
        logic coreRight;
        logic coreWr;
        logic coreRd;
        logic fault;
        logic [31:0] rdata;
    } prr_main_t;

endpackage

// ---- prr_xlate_if.sv ----
// lookup-to-check carrier between the top and the entry checker
// assumes all signals are combinational within one ref_clk cycle
interface prr_xlate_if;
    logic [11:0] entry;
    logic [14:0] progAddr;
    logic isWrite;
    logic locZero;
    logic suppress;
    logic [17:0] physAddr;
    logic exclFault;
    logic unaddrFault;
    logic lenFault;

    modport check (
        input entry, progAddr, isWrite, locZero, suppress,
        output physAddr, exclFault, unaddrFault, lenFault
    );
    modport user (
        output entry, progAddr, isWrite, locZero, suppress,
        input physAddr, exclFault, unaddrFault, lenFault
    );
endinterface

// ---- prr_index_file.sv ----
// page map storage: locations of two indexes each, one write port and two
// combinational read ports; contents are not reset, software loads them
module prr_index_file
    import prr_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int INDEX_W = 12,
    parameter int LOC_W = $clog2(DEPTH)
)
(
    input wire logic ref_clk,
    input wire logic wrEn,
    input wire logic [LOC_W-1:0] wrLoc,
    input wire logic wrHalf,
    input wire logic [INDEX_W-1:0] wrData,
    input wire logic [LOC_W-1:0] lkLoc,
    input wire logic lkHalf,
    output logic [INDEX_W-1:0] lkEntry,
    input wire logic [LOC_W-1:0] swLoc,
    input wire logic swHalf,
    output logic [INDEX_W-1:0] swEntry
);
    // even index in the upper half, odd index in the lower half
    logic [2*INDEX_W-1:0] mem [DEPTH];

    // one index written at a time, the other half of the word kept
    always_ff @(posedge ref_clk)
    begin
        if (wrEn)
        begin
            if (wrHalf)
                mem[wrLoc][INDEX_W-1:0] <= wrData;
            else
                mem[wrLoc][2*INDEX_W-1:INDEX_W] <= wrData;
        end
    end

    // address bit 11 picks the index of the pair [R2]
    assign lkEntry = lkHalf ? mem[lkLoc][INDEX_W-1:0]
                            : mem[lkLoc][2*INDEX_W-1:INDEX_W];
    assign swEntry = swHalf ? mem[swLoc][INDEX_W-1:0]
                            : mem[swLoc][2*INDEX_W-1:INDEX_W];
endmodule

// ---- prr_entry_check.sv ----
// decodes one page map entry against a program address: relocation and
// protection checks, purely combinational; clock only for its assertions
`include "prr_defines.svh"
module prr_entry_check
    import prr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    prr_xlate_if.check x
);
    logic excl;
    logic [1:0] qLen;
    logic [6:0] page;
    logic [1:0] startQ;
    logic [1:0] relQ;
    logic [1:0] physQ;

    // field split; location zero forces page and start quarter to zero
    always_comb
    begin
        excl = x.entry[`PRR_EXCL_BIT]; // [R4]
        qLen = x.entry[`PRR_QLEN_MSB:`PRR_QLEN_LSB];
        page = x.locZero ? 7'h00 : x.entry[`PRR_PAGE_MSB:`PRR_PAGE_LSB]; // [R18]
        startQ = x.locZero ? 2'h0 : x.entry[`PRR_SQ_MSB:`PRR_SQ_LSB]; // [R18]
        relQ = x.progAddr[`PRR_PA_QTR_MSB:`PRR_PA_QTR_LSB];
        physQ = 2'(startQ + relQ); // carry dropped, wraps in page [R12] [R13]
    end

    // page on top, quarter sum, then the word offset unchanged
    assign x.physAddr = {page, physQ,
        x.progAddr[`PRR_PA_WORD_MSB:0]}; // [R8] [R11] [R16] [R17]

    // write-excluded page, unaddressable page, quarter beyond length
    assign x.exclFault = x.isWrite && excl
        && ({qLen, page, startQ} != 11'h000); // [R5] [R6]
    assign x.unaddrFault = excl && ({qLen, page, startQ} == 11'h000); // [R7]
    assign x.lenFault = !x.suppress && (qLen != 2'h0)
        && (relQ >= qLen); // zero length is a full page [R10] [R14] [R15]

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    lenLimit_a: assert property ( // [R14]
        (x.entry[`PRR_QLEN_MSB:`PRR_QLEN_LSB] == 2'h1) && !x.suppress
        && (x.progAddr[10:9] == 2'h3) |-> x.lenFault)
        else $error("quarter length fault missed");
    lenQuiet_a: assert property ( // [R15]
        x.suppress |-> !x.lenFault)
        else $error("length fault in supervisor or io");
    unaddr_a: assert property ( // [R7]
        (x.entry == 12'h800) && !x.isWrite |-> x.unaddrFault && !x.exclFault)
        else $error("unaddressable page not flagged");
endmodule

// ---- prr_top.sv ----
// page relocation unit: turns a 15-bit program address and a 3-bit group
// number into an 18-bit core address with protection checks; assumes the
// processor drives its pulses from logic on ref_clk
//
// How it works
// R1: group and top four bits pick entry
// R2: address bit 11 picks half of location
// R3: group zero in supervisor, else mode-selected; PRR_MON_OPER operands use the operand group
// R4: entry holds exclusion, length, page, start quarter
// R5: exclusion clear allows reads and writes
// R6: excluded nonzero entry faults on writes
// R7: excluded all-zero entry is unaddressable, faults
// R8: page field gives the top seven bits
// R9: address bit 17 picks left or right
// R10: pages are four quarters, zero length full
// R11: start quarter sets first physical quarter
// R12: quarter adder sums start quarter, bits 9-10
// R13: adder carry dropped, quarter wraps
// R14: quarter at or beyond length faults
// R15: no length fault in supervisor or io
// R16: page and adder sum form high bits
// R17: low nine bits pass unchanged
// R18: location zero forces page and quarter zero
// R19: faulting write never reaches core
//
// Chosen here: the register offsets and the plain strobed port.
`include "prr_defines.svh"
module prr_top
    import prr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic refValid,
    input wire logic refWrite,
    input wire logic refInstr,
    input wire logic refIo,
    input wire logic [14:0] refProgAddr,
    input wire logic enterProgram,
    input wire logic relocOperand,
    input wire logic relocInstr,
    input wire logic interruptTaken,
    output logic [17:0] coreAddr,
    output logic coreLeftSel,
    output logic coreRightSel,
    output logic coreWrEn,
    output logic coreRdEn,
    output logic illegalWrite,
    output logic supervisorState,
    output logic irq
);
    prr_main_t st_ff;
    prr_main_t nxt_st;
    prr_xlate_if x ();
    logic [2:0] group;
    logic [11:0] swEntry;
    logic mapWr;
    logic anyFault;
    logic [2:0] events;
    logic [2:0] clearBits;
    logic fetch;

    // ****************************************************************
    // group selection and lookup
    // ****************************************************************

    // an io transfer is never a fetch, even if the fetch flag is left high,
    // so channel data lands in the operand group in both operand modes
    assign fetch = refInstr && !refIo;

    // instruction fetches follow program state, operands follow the mode;
    // io references take the operand group in the two operand modes
    always_comb
    begin
        group = `PRR_GROUP_RST; // supervisor start and interrupts [R3]
        case (st_ff.mode)
            PRR_MON_INIT: group = `PRR_GROUP_RST;
            PRR_MON_OPER: group = fetch ? `PRR_GROUP_RST : st_ff.operGroup;
            PRR_PROG_OPER: group = fetch ? st_ff.instrGroup
                                         : st_ff.operGroup; // [R3]
            PRR_PROG_INSTR: group = st_ff.instrGroup; // [R3]
            default: group = `PRR_GROUP_RST;
        endcase
    end

    // map data port writes the index that the map pointer names
    assign mapWr = regWr && (regAddr == `PRR_OFF_MAP_DATA);

    // group in the high location bits, address bits 14..12 below [R1]
    prr_index_file #(
        .DEPTH(64),
        .INDEX_W(12)
    ) u_file (
        .ref_clk(ref_clk),
        .wrEn(mapWr),
        .wrLoc(st_ff.mapPtr[6:1]),
        .wrHalf(st_ff.mapPtr[0]),
        .wrData(regWdata[11:0]),
        .lkLoc({group, refProgAddr[`PRR_PA_LOC_MSB:`PRR_PA_LOC_LSB]}), // [R1]
        .lkHalf(refProgAddr[`PRR_PA_HALF_BIT]), // [R2]
        .lkEntry(x.entry),
        .swLoc(st_ff.mapPtr[6:1]),
        .swHalf(st_ff.mapPtr[0]),
        .swEntry(swEntry)
    );

    // location zero is group zero with bits 14..12 clear, both halves
    assign x.progAddr = refProgAddr;
    assign x.isWrite = refWrite;
    assign x.locZero = (group == 3'h0)
        && (refProgAddr[`PRR_PA_LOC_MSB:`PRR_PA_LOC_LSB] == 3'h0); // [R18]
    assign x.suppress = !st_ff.mode[1] || refIo; // [R15]

    prr_entry_check u_check (
        .ref_clk(ref_clk),
        .rst(rst),
        .x(x)
    );

    // ****************************************************************
    // fault events and interrupt status
    // ****************************************************************
    // one event bit per fault kind, only for a taken reference
    always_comb
    begin
        events = 3'h0;
        events[`PRR_ST_EXCL] = refValid && x.exclFault;
        events[`PRR_ST_UNADDR] = refValid && x.unaddrFault;
        events[`PRR_ST_QLEN] = refValid && x.lenFault;
        anyFault = |events;
        clearBits = (regWr && (regAddr == `PRR_OFF_STATUS))
            ? regWdata[2:0] : 3'h0;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        nxt_st = st_ff;

        // mode walk; an interrupt beats every other pulse [R3]
        if (interruptTaken)
            nxt_st.mode = PRR_MON_INIT;
        else if (enterProgram)
            nxt_st.mode = (st_ff.mode == PRR_MON_OPER) ? PRR_PROG_OPER
                        : (st_ff.mode == PRR_MON_INIT) ? PRR_PROG_INSTR
                        : st_ff.mode;
        else if (relocOperand)
            nxt_st.mode = st_ff.mode[1] ? PRR_PROG_OPER : PRR_MON_OPER;
        else if (relocInstr)
            nxt_st.mode = st_ff.mode[1] ? PRR_PROG_INSTR : PRR_MON_INIT;

        // register writes; the map data port is written through mapWr
        if (regWr)
        begin
            case (regAddr)
                `PRR_OFF_CTRL:
                begin
                    nxt_st.instrGroup = regWdata[`PRR_CTRL_IGRP_LSB +: 3];
                    nxt_st.operGroup = regWdata[`PRR_CTRL_OGRP_LSB +: 3];
                end
                `PRR_OFF_MASK: nxt_st.mask = regWdata[2:0];
                `PRR_OFF_MAP_PTR: nxt_st.mapPtr = regWdata[6:0];
                default: nxt_st.mapPtr = st_ff.mapPtr;
            endcase
        end

        // sticky status: a fault in the clearing cycle stays set
        nxt_st.status = (st_ff.status & ~clearBits) | events;

        // core strobes last one cycle; a faulting write is withheld
        nxt_st.coreLeft = 1'b0;
        nxt_st.coreRight = 1'b0;
        nxt_st.coreWr = 1'b0;
        nxt_st.coreRd = 1'b0;
        nxt_st.fault = 1'b0;
        if (refValid)
        begin
            nxt_st.coreAddr = x.physAddr; // [R16] [R17]
            nxt_st.lastGroup = group;
            nxt_st.fault = anyFault;
            nxt_st.coreLeft = !anyFault && x.physAddr[17]; // [R9]
            nxt_st.coreRight = !anyFault && !x.physAddr[17]; // [R9]
            nxt_st.coreWr = refWrite && !anyFault; // [R19]
            nxt_st.coreRd = !refWrite && !anyFault;
            if (anyFault)
                nxt_st.faultAddr = {group, refProgAddr};
        end

        // read data stands in the cycle after the strobe only
        nxt_st.rdata = 32'h0;
        if (regRd)
        begin
            case (regAddr)
                `PRR_OFF_CTRL:
                    nxt_st.rdata = {25'h0, st_ff.operGroup, 1'b0,
                                    st_ff.instrGroup};
                `PRR_OFF_STATUS: nxt_st.rdata = {29'h0, st_ff.status};
                `PRR_OFF_MASK: nxt_st.rdata = {29'h0, st_ff.mask};
                `PRR_OFF_MODE:
                    nxt_st.rdata = {25'h0, st_ff.lastGroup, 2'h0,
                                    st_ff.mode};
                `PRR_OFF_MAP_PTR: nxt_st.rdata = {25'h0, st_ff.mapPtr};
                `PRR_OFF_MAP_DATA: nxt_st.rdata = {20'h0, swEntry};
                `PRR_OFF_FAULT_ADDR: nxt_st.rdata = {14'h0, st_ff.faultAddr};
                default: nxt_st.rdata = 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // synchronous reset only; the page map is left alone so that a reset
    // does not cost software a full reload of the tables
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_ff <= prr_main_t'('0);
            st_ff.status <= `PRR_STATUS_RST;
            st_ff.mask <= `PRR_MASK_RST;
        end
        else
            st_ff <= nxt_st;
    end

    // outputs straight from flip-flops except the level interrupt and the inverted supervisorState;
    // irq falls as soon as software clears or masks the bit
    assign regRdata = st_ff.rdata;
    assign coreAddr = st_ff.coreAddr;
    assign coreLeftSel = st_ff.coreLeft;
    assign coreRightSel = st_ff.coreRight;
    assign coreWrEn = st_ff.coreWr;
    assign coreRdEn = st_ff.coreRd;
    assign illegalWrite = st_ff.fault;
    assign supervisorState = !st_ff.mode[1];
    assign irq = |(st_ff.status & st_ff.mask);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    wrBlock_a: assert property ( // [R19]
        refValid && refWrite && (x.exclFault || x.lenFault)
        |=> illegalWrite && !coreWrEn && !coreLeftSel && !coreRightSel)
        else $error("faulting write reached core");
    busPick_a: assert property ( // [R9]
        (coreLeftSel |-> coreAddr[17]) and (coreRightSel |-> !coreAddr[17]))
        else $error("wrong storage bus picked");
    lowBits_a: assert property ( // [R17]
        refValid |=> coreAddr[8:0] == $past(refProgAddr[8:0]))
        else $error("word offset altered");
    quarterSum_a: assert property ( // [R12]
        refValid && !x.locZero |=> coreAddr[10:9]
            == 2'($past(x.entry[1:0]) + $past(refProgAddr[10:9])))
        else $error("quarter adder wrong");
    pageZero_a: assert property ( // [R18]
        refValid && x.locZero |=> coreAddr[17:11] == 7'h00)
        else $error("location zero not forced");
    // an interrupt drops to initial supervisor, which looks up group zero
    intrMode_a: assert property ( // [R3]
        interruptTaken |=> supervisorState && (st_ff.mode == PRR_MON_INIT))
        else $error("interrupt did not reach initial supervisor");
    groupZero_a: assert property ( // [R3]
        (st_ff.mode == PRR_MON_INIT) && refValid |=> st_ff.lastGroup == 3'h0)
        else $error("group not zero in initial supervisor");

    // location zero is left out: forcing its page and start quarter to zero
    // turns an excluded entry there with a zero length into an unaddressable one
    readOnly_a: assert property ( // [R6]
        refValid && refWrite && !x.locZero && x.entry[11]
        && (x.entry[10:0] != 11'h0) |=> illegalWrite && st_ff.status[0])
        else $error("write to excluded page passed");
    setWins_a: assert property ( // [R6]
        refValid && x.exclFault |=> st_ff.status[0])
        else $error("exclusion event lost in status");

    // a mask write in the same cycle may legally hide the event
    irqRaise_a: assert property (
        refValid && x.unaddrFault && st_ff.mask[1] && !regWr |=> irq)
        else $error("unmasked fault without interrupt");

    // one bus and one direction per reference; read data one cycle only
    oneBus_a: assert property ( // [R9]
        !(coreLeftSel && coreRightSel) && !(coreWrEn && coreRdEn))
        else $error("two core strobes at once");
    rdIdle_a: assert property (
        !$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its cycle");

    readCov_c: cover property (refValid && !refWrite ##1 coreRdEn);
    writeCov_c: cover property (refValid && refWrite ##1 coreWrEn);
    faultCov_c: cover property (illegalWrite ##1 irq);
    progCov_c: cover property (enterProgram ##1 refValid ##1 coreLeftSel);
    intrCov_c: cover property (interruptTaken ##1 supervisorState);
endmodule

// ---- prr_core_model.sv ----
// core storage model standing on the far side of the relocation unit
// assumes one-cycle strobes from prr_top, all on ref_clk
module prr_core_model
(
    input wire logic ref_clk,
    input wire logic [17:0] coreAddr,
    input wire logic coreLeftSel,
    input wire logic coreRightSel,
    input wire logic coreWrEn,
    output int nWrites,
    output int nBadSel
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // storage side bookkeeping
    // ****************************************************************
    // counters are ints and start at zero, so one process drives each
    // only stored words are counted, so a refused write shows as a shortfall
    always @(posedge ref_clk)
    begin
        if (coreWrEn)
            nWrites <= nWrites + 1;
        if ((coreLeftSel && !coreAddr[17]) || (coreRightSel && coreAddr[17]))
            nBadSel <= nBadSel + 1;
    end
endmodule

// ---- prr_top_tb.sv ----
// self-checking bench for the page relocation unit
// assumes prr_top, prr_core_model and prr_defines.svh are compiled first
`include "prr_defines.svh"
module prr_top_tb
    import prr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic ref_clk, rst, regWr, regRd, refValid, refWrite, refInstr, refIo;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [14:0] refProgAddr;
    logic [3:0] modeReq;
    logic [17:0] coreAddr;
    logic coreLeftSel, coreRightSel, coreWrEn, coreRdEn;
    logic illegalWrite, supervisorState, irq;
    logic [2:0] instruction_group_register, operand_group_register;
    prr_mode_t mode;
    int nFail, checks, expWrites, nWrites, nBadSel;

    prr_top prr_top_inst (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .refValid(refValid), .refWrite(refWrite),
        .refInstr(refInstr), .refIo(refIo), .refProgAddr(refProgAddr),
        .enterProgram(modeReq[0]), .relocOperand(modeReq[1]),
        .relocInstr(modeReq[2]), .interruptTaken(modeReq[3]),
        .coreAddr(coreAddr), .coreLeftSel(coreLeftSel),
        .coreRightSel(coreRightSel), .coreWrEn(coreWrEn),
        .coreRdEn(coreRdEn), .illegalWrite(illegalWrite),
        .supervisorState(supervisorState), .irq(irq));

    prr_core_model prr_core_model_inst (.ref_clk(ref_clk),
        .coreAddr(coreAddr), .coreLeftSel(coreLeftSel),
        .coreRightSel(coreRightSel), .coreWrEn(coreWrEn),
        .nWrites(nWrites), .nBadSel(nBadSel));

    // ****************************************************************
    // prediction, bus tasks and checks
    // ****************************************************************
    // {fault, physical address} of one reference
    function automatic logic [18:0] predict(input logic [11:0] e,
        input logic [14:0] a, input logic [2:0] g, input logic wr,
        input logic sup, input logic io);
        logic [6:0] pg;
        logic [1:0] sq;
        logic bad;
        pg = (g == 3'h0 && a[14:12] == 3'h0) ? 7'h0 : e[8:2];
        sq = (g == 3'h0 && a[14:12] == 3'h0) ? 2'h0 : e[1:0];
        bad = e[11] && (wr || e[10:0] == 11'h0);
        if (e[10:9] != 2'h0 && a[10:9] >= e[10:9] && !sup && !io)
            bad = 1'b1;
        predict = {bad, pg, a[10:9] + sq, a[8:0]};
    endfunction

    // io references use the operand group as well in the two operand modes
    function automatic logic [2:0] groupOf(input logic ins, input logic io);
        case (mode)
            PRR_MON_INIT: groupOf = 3'h0;
            PRR_MON_OPER: groupOf = (ins && !io) ? 3'h0 : operand_group_register;
            PRR_PROG_INSTR: groupOf = instruction_group_register;
            default: groupOf = (ins && !io) ? instruction_group_register : operand_group_register;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            nFail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic regCheck(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        logic [31:0] d;
        regRead(a, d);
        check(what, exp, d);
    endtask

    // load the entry, then make one reference in the current mode
    task automatic oneRef(input logic [14:0] a, input logic wr,
        input logic io, input logic ins, input logic [11:0] e);
        logic [2:0] g;
        logic [18:0] p;
        g = groupOf(ins, io);
        if (g == 3'h0 && a[14:12] == 3'h0)
            e[11] = 1'b0;
        p = predict(e, a, g, wr, !mode[1], io);
        regWrite(`PRR_OFF_MAP_PTR, {25'h0, g, a[14:11]});
        regWrite(`PRR_OFF_MAP_DATA, {20'h0, e});
        regCheck(`PRR_OFF_MAP_DATA, {20'h0, e}, "entry");
        @(posedge ref_clk);
        refValid <= 1'b1;
        refWrite <= wr;
        refIo <= io;
        refInstr <= ins;
        refProgAddr <= a;
        @(posedge ref_clk);
        refValid <= 1'b0;
        #1;
        expWrites += (!p[18] && wr);
        check("fault", p[18], illegalWrite);
        if (!p[18])
            check("addr", p[17:0], coreAddr);
        check("left", !p[18] && p[17], coreLeftSel);
        check("right", !p[18] && !p[17], coreRightSel);
        check("wr", !p[18] && wr, coreWrEn);
        check("rd", !p[18] && !wr, coreRdEn);
    endtask

    task automatic randRefs(input int n);
        repeat (n)
            oneRef($urandom, $urandom, $urandom, $urandom, $urandom);
    endtask

    task automatic modeStep(input int k, input prr_mode_t m);
        logic [31:0] d;
        @(posedge ref_clk);
        modeReq[k] <= 1'b1;
        @(posedge ref_clk);
        modeReq <= 4'h0;
        mode = m;
        regRead(`PRR_OFF_MODE, d);
        check("mode", m, d[1:0]);
        check("sup", !m[1], supervisorState);
    endtask

    task automatic stopTest();
        if (nFail == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // clock, timeout and main sequence
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // a hang counts as a mismatch
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        nFail++;
        stopTest();
    end

    initial
    begin
        logic [28:0] cor [7];
        cor = '{{15'h1200, 1'b1, 1'b0, 12'h204},
            {15'h1200, 1'b1, 1'b1, 12'h204}, {15'h1400, 1'b0, 1'b0, 12'h015},
            {15'h1600, 1'b1, 1'b0, 12'h017}, {15'h1000, 1'b0, 1'b0, 12'h800},
            {15'h1000, 1'b1, 1'b0, 12'h9fc}, {15'h1000, 1'b0, 1'b0, 12'h9fc}};
        {rst, regWr, regRd, refValid, refWrite, refInstr, refIo} = 7'h40;
        {regAddr, regWdata, refProgAddr, modeReq} = 59'h0;
        nFail = 0;
        checks = 0;
        expWrites = 0;
        mode = PRR_MON_INIT;
        void'($urandom(32'h9b854fe3));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        regCheck(`PRR_OFF_MODE, 32'h0, "mode rst");
        regCheck(`PRR_OFF_STATUS, 32'h0, "status rst");
        regCheck(`PRR_OFF_MASK, 32'h0, "mask rst");
        regCheck(8'h1c, 32'h0, "unmapped");
        instruction_group_register = $urandom;
        operand_group_register = $urandom;
        regWrite(`PRR_OFF_CTRL, {25'h0, operand_group_register, 1'b0, instruction_group_register});
        regCheck(`PRR_OFF_CTRL, {25'h0, operand_group_register, 1'b0, instruction_group_register}, "ctrl");
        oneRef(15'h07ff, 1'b1, 1'b0, 1'b0, 12'h1ff);
        randRefs(40);
        modeStep(1, PRR_MON_OPER);
        randRefs(30);
        modeStep(0, PRR_PROG_OPER);
        foreach (cor[i])
            oneRef(cor[i][28:14], cor[i][13], cor[i][12], 1'b0, cor[i][11:0]);
        randRefs(40);
        modeStep(2, PRR_PROG_INSTR);
        randRefs(30);
        modeStep(3, PRR_MON_INIT);
        // unaddressable read raises a masked-in event, then cleared
        regWrite(`PRR_OFF_STATUS, 32'h7);
        regWrite(`PRR_OFF_MASK, 32'h2);
        oneRef(15'h3000, 1'b0, 1'b0, 1'b0, 12'h800);
        check("irq", 1'b1, irq);
        regCheck(`PRR_OFF_STATUS, 32'h2, "status");
        regCheck(`PRR_OFF_FAULT_ADDR, 32'h3000, "fault addr");
        regWrite(`PRR_OFF_STATUS, 32'h2);
        #1 check("irq clr", 1'b0, irq);
        // masked-out event still lands in status
        oneRef(15'h3000, 1'b1, 1'b0, 1'b0, 12'h9fc);
        check("irq mask", 1'b0, irq);
        regCheck(`PRR_OFF_STATUS, 32'h1, "status ex");
        check("stored", expWrites, nWrites);
        check("bus sel", 0, nBadSel);
        stopTest();
    end
endmodule
